// >>> bench/sos_monitor.sv
// port assertions for the orientation sequencer, bound into it
`timescale 1ns/1ps
`default_nettype none
module sos_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic orient_cmd,
   input wire logic enc_index,
   input wire logic in_position,
   input wire logic [7:0] orient_decel_ratio,
   input wire logic [7:0] lag_lead_comp_gain,
   input wire logic [7:0] main_display_select,
   input wire logic [7:0] decel_ratio_out,
   input wire logic pi_comp_sel,
   input wire logic show_position_pulse,
   input wire logic position_mode,
   input wire logic pid_enable,
   input wire logic orient_done_out,
   input wire logic encoder_loss_fault
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_pi; $past(rst_n) && $stable(lag_lead_comp_gain)
      |-> pi_comp_sel == (lag_lead_comp_gain == 8'h00); endproperty
   a_pi: assert property (p_pi) else $error("pi select wrong");
   property p_disp; $past(rst_n) && $stable(main_display_select)
      |-> show_position_pulse == (main_display_select == 8'h13); endproperty
   a_disp: assert property (p_disp) else $error("display wrong");
   property p_pid; position_mode |-> !pid_enable; endproperty
   a_pid: assert property (p_pid) else $error("pid on");
   property p_dec; $past(rst_n) |-> decel_ratio_out == $past(orient_decel_ratio);
   endproperty
   a_dec: assert property (p_dec) else $error("decel ratio");
   property p_end; $fell(orient_cmd) && !encoder_loss_fault
      |-> ##[1:6] !position_mode && pid_enable; endproperty
   a_end: assert property (p_end) else $error("orient not ended");
   property p_idx; $rose(position_mode) |-> $past(enc_index); endproperty
   a_idx: assert property (p_idx) else $error("no index first");
   property p_done; orient_done_out |-> position_mode && $past(in_position);
   endproperty
   a_done: assert property (p_done) else $error("early done");
   property p_trip; encoder_loss_fault |=> encoder_loss_fault; endproperty
   a_trip: assert property (p_trip) else $error("fault cleared");
   c_done: cover property ($rose(orient_done_out));
   c_pos: cover property ($rose(position_mode));
   c_trip: cover property ($rose(encoder_loss_fault));
endmodule
bind sos_sequencer sos_monitor mon_u (
   .clock(clock), .rst_n(rst_n), .orient_cmd(orient_cmd),
   .enc_index(enc_index), .in_position(in_position),
   .orient_decel_ratio(orient_decel_ratio),
   .lag_lead_comp_gain(lag_lead_comp_gain),
   .main_display_select(main_display_select),
   .decel_ratio_out(decel_ratio_out), .pi_comp_sel(pi_comp_sel),
   .show_position_pulse(show_position_pulse),
   .position_mode(position_mode), .pid_enable(pid_enable),
   .orient_done_out(orient_done_out),
   .encoder_loss_fault(encoder_loss_fault)
);
`default_nettype wire

// >>> bench/sos_partner.sv
// motor and shaft encoder model on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module sos_partner (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enc_off,
   input wire logic dir_reverse,
   input wire logic position_mode,
   input wire logic [15:0] speed_target,
   output logic enc_pulse,
   output logic enc_index,
   output logic motor_reverse,
   output logic in_position,
   output logic [15:0] motor_speed
);
   logic [3:0] ph_r;
   // encoder goes silent only when the bench cuts the cable
   assign enc_pulse = ph_r[0] && !enc_off;
   assign enc_index = ph_r == 4'hf && !enc_off;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= 4'h0;
         motor_speed <= 16'h0bb8;
         motor_reverse <= 1'b1;
         in_position <= 1'b0;
      end else begin
         ph_r <= ph_r + 4'h1;
         // loop settles at once: servo gains taken as tuned
         in_position <= position_mode;
         if (speed_target == 16'hffff && motor_speed < 16'h0bb8)
            motor_speed <= motor_speed + 16'h0064;
         else if (speed_target != 16'hffff && motor_speed > speed_target)
            motor_speed <= motor_speed - 16'h0064;
         // direction can only turn over at standstill
         if (motor_speed == 16'h0000)
            motor_reverse <= dir_reverse;
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// testbench: orientation in each direction mode, then encoder loss
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0, rst_n = 1'b0, orient_cmd = 1'b0, enc_off = 1'b0;
   logic fwd_run_input = 1'b1, rev_run_input = 1'b0, exp_rev = 1'b1;
   logic [1:0] orient_direction_select = 2'h0;
   logic [15:0] orient_switch_speed = sos_pkg::ORIENT_SPEED_RST;
   logic [7:0] orient_decel_ratio = 8'h14;
   logic [7:0] lag_lead_comp_gain = 8'h00, main_display_select = 8'h00;
   logic enc_pulse, enc_index, motor_reverse, in_position, dir_reverse;
   logic position_mode, pi_comp_sel, pid_enable, orient_done_out;
   logic encoder_loss_fault, show_position_pulse;
   logic [15:0] motor_speed, speed_target;
   logic [7:0] decel_ratio_out;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   sos_sequencer #(.ENC_TIMEOUT(50)) dut_u (
      .clock(clock), .rst_n(rst_n), .orient_cmd(orient_cmd),
      .fwd_run_input(fwd_run_input), .rev_run_input(rev_run_input),
      .enc_pulse(enc_pulse), .enc_index(enc_index),
      .orient_direction_select(orient_direction_select),
      .orient_switch_speed(orient_switch_speed),
      .orient_decel_ratio(orient_decel_ratio),
      .lag_lead_comp_gain(lag_lead_comp_gain),
      .main_display_select(main_display_select),
      .motor_speed(motor_speed), .motor_reverse(motor_reverse),
      .in_position(in_position), .speed_target(speed_target),
      .dir_reverse(dir_reverse), .position_mode(position_mode),
      .pi_comp_sel(pi_comp_sel), .decel_ratio_out(decel_ratio_out),
      .pid_enable(pid_enable), .orient_done_out(orient_done_out),
      .encoder_loss_fault(encoder_loss_fault),
      .show_position_pulse(show_position_pulse)
   );
   sos_partner far_u (
      .clock(clock), .rst_n(rst_n), .enc_off(enc_off),
      .dir_reverse(dir_reverse), .position_mode(position_mode),
      .speed_target(speed_target), .enc_pulse(enc_pulse),
      .enc_index(enc_index), .motor_reverse(motor_reverse),
      .in_position(in_position), .motor_speed(motor_speed)
   );
   initial forever #2.5 clock = ~clock;
   always @(posedge clock) if (++cyc == 20000) begin
      n_mismatch++;
      close_out();
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      step(8);
      rst_n = 1'b1;
      step(2);
      check("pid_enable", pid_enable, 1'b1);
      check("decel_ratio_out", decel_ratio_out, 8'h14);
      for (int i = 0; i < 4; i++) begin
         lag_lead_comp_gain = i[0] ? 8'h05 : 8'h00;
         main_display_select = i[1] ? 8'h13 : 8'h12;
         step(3);
         check("pi_comp_sel", pi_comp_sel, !i[0]);
         check("show_position_pulse", show_position_pulse, i[1]);
      end
      for (int m = 0; m < 3; m++) begin
         orient_direction_select = m[1:0];
         if (m > 0) exp_rev = (m == 2);
         orient_cmd = 1'b1;
         for (int k = 0; k < 3000 && orient_done_out !== 1'b1; k++) step(1);
         check("orient_done_out", orient_done_out, 1'b1);
         check("pid_enable", pid_enable, 1'b0);
         check("motor_reverse", motor_reverse, exp_rev);
         check("dir_reverse", dir_reverse, exp_rev);
         check("speed_target", speed_target, orient_switch_speed);
         // last run keeps start on to see the speed resume
         if (m < 2) fwd_run_input = 1'b0;
         step(2);
         orient_cmd = 1'b0;
         step(6);
         check("position_mode", position_mode, 1'b0);
         check("speed_target", speed_target, 16'hffff);
         fwd_run_input = 1'b1;
         step(40);
      end
      enc_off = 1'b1;
      orient_cmd = 1'b1;
      step(80);
      orient_cmd = 1'b0;
      step(8);
      check("encoder_loss_fault", encoder_loss_fault, 1'b1);
      check("speed_target", speed_target, 16'h0000);
      check("orient_done_out", orient_done_out, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire

// >>> src/sos_pkg.sv
// constants and types for the spindle orientation sequencer
package sos_pkg;
   localparam logic [1:0] DIR_CURRENT = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;
   localparam logic [7:0] DECEL_RATIO_RST = 8'h14;
   // speeds in 0.01 Hz units
   localparam logic [15:0] ORIENT_SPEED_RST = 16'h00c8;
   localparam logic [7:0] DISP_POS_PULSE = 8'h13;
   localparam int ENC_TIMEOUT_MS = 100;
   localparam int CLK_KHZ = 200000;
   localparam int ENC_TIMEOUT_CYC = ENC_TIMEOUT_MS * CLK_KHZ;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DECEL = 3'h1,
      ST_INDEX = 3'h3,
      ST_POSN = 3'h2,
      ST_HOLD = 3'h6,
      ST_REVERSE = 3'h7,
      ST_TRIP = 3'h5
   } sos_state_t;
endpackage

// >>> src/sos_sequencer.sv
// spindle orientation sequencer: speed to position loop handover
`timescale 1ns/1ps
`default_nettype none
module sos_sequencer #(
   parameter int ENC_TIMEOUT = sos_pkg::ENC_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   // run and orientation pins, asynchronous to clock
   input wire logic orient_cmd,
   input wire logic fwd_run_input,
   input wire logic rev_run_input,
   // encoder and motor feedback, same clock
   input wire logic enc_pulse,
   input wire logic enc_index,
   // settings, held steady by the caller
   input wire logic [1:0] orient_direction_select,
   input wire logic [15:0] orient_switch_speed,
   input wire logic [7:0] orient_decel_ratio,
   input wire logic [7:0] lag_lead_comp_gain,
   input wire logic [7:0] main_display_select,
   input wire logic [15:0] motor_speed,
   input wire logic motor_reverse,
   input wire logic in_position,
   // outputs, all registered
   output logic [15:0] speed_target,
   output logic dir_reverse,
   output logic position_mode,
   output logic pi_comp_sel,
   output logic [7:0] decel_ratio_out,
   output logic pid_enable,
   output logic orient_done_out,
   output logic encoder_loss_fault,
   output logic show_position_pulse
);
   typedef struct packed {
      // one lane per pin: 0 orient, 1 forward, 2 reverse
      logic [2:0][sos_pkg::SYNC_STAGES-1:0] sync_s;
      logic [2:0] steady;
      sos_pkg::sos_state_t st;
      // cycles since the last encoder pulse
      logic [31:0] enc_cnt;
      logic [15:0] speed_target;
      logic dir_reverse;
      logic position_mode;
      logic pi_comp_sel;
      logic [7:0] decel_ratio;
      logic pid_enable;
      logic done;
      logic fault;
      logic show_pos;
   } sos_regs_t;

   // speed_target: ffff follows the run command, 0 stops, anything
   // else is the orientation speed in 0.01 Hz
   localparam int SYNC_LAST = sos_pkg::SYNC_STAGES - 1;
   localparam sos_regs_t REGS_RST = '{
      sync_s: '0,
      steady: 3'h0,
      st: sos_pkg::ST_IDLE,
      enc_cnt: 32'h0,
      speed_target: 16'h0,
      dir_reverse: 1'b0,
      position_mode: 1'b0,
      pi_comp_sel: 1'b0,
      decel_ratio: sos_pkg::DECEL_RATIO_RST,
      pid_enable: 1'b1,
      done: 1'b0,
      fault: 1'b0,
      show_pos: 1'b0
   };

   sos_regs_t q_r;
   sos_regs_t q_nxt;
   wire logic [2:0] pin_in;
   wire logic [2:0][sos_pkg::SYNC_STAGES-1:0] sync_nxt;
   wire logic [2:0] pin_v;
   logic orient_v;
   logic fwd_v;
   logic rev_v;
   logic want_rev;
   logic dir_ok;

   ////////////////////////////////////////////////////////////////
   // three stages per pin; a change counts when the last two agree,
   // so a one-cycle glitch never reaches the sequencer
   assign pin_in = {rev_run_input, fwd_run_input, orient_cmd};
   for (genvar g = 0; g < 3; g++) begin : g_sync
      assign sync_nxt[g] = {q_r.sync_s[g][SYNC_LAST-1:0], pin_in[g]};
      assign pin_v[g] = (q_r.sync_s[g][SYNC_LAST]
                         == q_r.sync_s[g][SYNC_LAST-1])
                        ? q_r.sync_s[g][SYNC_LAST] : q_r.steady[g];
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      q_nxt = q_r;
      q_nxt.sync_s = sync_nxt;
      q_nxt.steady = pin_v;
      orient_v = pin_v[0];
      fwd_v = pin_v[1];
      rev_v = pin_v[2];
      // direction wanted at the final approach
      case (orient_direction_select)
         sos_pkg::DIR_CURRENT: want_rev = motor_reverse;
         sos_pkg::DIR_FWD: want_rev = 1'b0;
         sos_pkg::DIR_REV: want_rev = 1'b1;
         default: want_rev = motor_reverse;
      endcase
      // a wrong-way motor first runs through the reversal state
      dir_ok = (want_rev == motor_reverse);
      // the ratio is only shaping data; the loop itself lives outside
      q_nxt.decel_ratio = orient_decel_ratio;
      // zero gain drops the lead/lag filter: stiffer but may cycle
      q_nxt.pi_comp_sel = (lag_lead_comp_gain == 8'h00);
      q_nxt.show_pos = (main_display_select == sos_pkg::DISP_POS_PULSE);
      // encoder watchdog runs only while the command is held
      // saturates, so a long cable break cannot wrap back to zero
      if (!orient_v || enc_pulse) begin
         q_nxt.enc_cnt = 32'h0;
      end else if (q_r.enc_cnt != 32'(ENC_TIMEOUT)) begin
         q_nxt.enc_cnt = q_r.enc_cnt + 32'h1;
      end
      case (q_r.st)
         sos_pkg::ST_IDLE: begin
            // follow the run command and leave the process PID on
            q_nxt.position_mode = 1'b0;
            q_nxt.done = 1'b0;
            q_nxt.pid_enable = 1'b1;
            q_nxt.speed_target = 16'hffff;
            q_nxt.dir_reverse = rev_v && !fwd_v;
            if (orient_v) begin
               q_nxt.pid_enable = 1'b0;
               q_nxt.st = dir_ok ? sos_pkg::ST_DECEL : sos_pkg::ST_REVERSE;
            end
         end
         sos_pkg::ST_REVERSE: begin
            // slow to a stop, then turn round
            // flipping direction at speed would fight the drive
            q_nxt.speed_target = 16'h0;
            if (motor_speed == 16'h0) begin
               q_nxt.dir_reverse = want_rev;
               q_nxt.st = sos_pkg::ST_DECEL;
            end
         end
         sos_pkg::ST_DECEL: begin
            // slow to the switch speed in the wanted direction
            q_nxt.speed_target = orient_switch_speed;
            q_nxt.dir_reverse = want_rev;
            if (motor_speed <= orient_switch_speed) begin
               q_nxt.st = sos_pkg::ST_INDEX;
            end
         end
         sos_pkg::ST_INDEX: begin
            // hold the switch speed until the marker pulse passes
            if (enc_index) begin
               q_nxt.position_mode = 1'b1;
               q_nxt.st = sos_pkg::ST_POSN;
            end
         end
         sos_pkg::ST_POSN: begin
            // the position loop outside steers; here we only watch
            if (in_position) begin
               q_nxt.done = 1'b1;
               q_nxt.st = sos_pkg::ST_HOLD;
            end
         end
         sos_pkg::ST_HOLD: begin
            // done tracks the zone, so a knock out of it drops done
            q_nxt.done = in_position;
         end
         sos_pkg::ST_TRIP: begin
            q_nxt.speed_target = 16'h0;
            q_nxt.position_mode = 1'b0;
            q_nxt.done = 1'b0;
         end
         default: q_nxt.st = sos_pkg::ST_IDLE;
      endcase
      // dropping the command ends orientation four clock edges later, once the pin filter passes it
      // controller is expected to drop start first
      if (!orient_v && q_r.st != sos_pkg::ST_IDLE
          && q_r.st != sos_pkg::ST_TRIP) begin
         q_nxt.st = sos_pkg::ST_IDLE;
         q_nxt.position_mode = 1'b0;
         q_nxt.done = 1'b0;
         q_nxt.pid_enable = 1'b1;
         // start still on: run back up to the speed command
         q_nxt.speed_target = (fwd_v || rev_v) ? 16'hffff : 16'h0;
         q_nxt.dir_reverse = rev_v && !fwd_v;
      end
      if (q_r.enc_cnt == 32'(ENC_TIMEOUT) && q_r.st != sos_pkg::ST_TRIP) begin
         q_nxt.st = sos_pkg::ST_TRIP;
         q_nxt.fault = 1'b1;
         // drop the position loop at once; only reset clears the trip
         q_nxt.position_mode = 1'b0;
         q_nxt.done = 1'b0;
         q_nxt.speed_target = 16'h0;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= REGS_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // every output is a register field, no logic after the flop
   assign speed_target = q_r.speed_target;
   assign dir_reverse = q_r.dir_reverse;
   assign position_mode = q_r.position_mode;
   assign pi_comp_sel = q_r.pi_comp_sel;
   assign decel_ratio_out = q_r.decel_ratio;
   assign pid_enable = q_r.pid_enable;
   assign orient_done_out = q_r.done;
   assign encoder_loss_fault = q_r.fault;
   assign show_position_pulse = q_r.show_pos;
endmodule
`default_nettype wire
